// ### core/mai_pkg.sv
// Package for the multidrop address interrogation block: opcodes, widths,
// reset values, state encodings and the backplane pin bundle.
// Assumes every user imports the whole package.
package mai_pkg;

   // Instruction and slot widths
   localparam int IR_LEN = 8;
   localparam int SLOT_W = 7;
   localparam int CNT_W = 4;

   // Opcodes seen at Update-IR
   localparam logic [IR_LEN-1:0] INTERROG_OP = 8'h3A;
   localparam logic [IR_LEN-1:0] RETURN_TO_WAIT_OP = 8'hFE;
   localparam logic [IR_LEN-1:0] BROADCAST_OP = 8'h8F;
   // Multicast groups share the upper six bits, low two bits pick the group
   localparam logic [IR_LEN-3:0] MULTICAST_BASE = 6'h23;

   // Capture-IR pattern outside interrogation: low two bits fixed, rest zero
   localparam logic [IR_LEN-1:0] CAPTURE_PAT = 8'h01;
   // Top bit of the presented address, above the slot pins
   localparam logic PAD_BIT = 1'b1;
   localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;

   // Reset values
   localparam logic [IR_LEN-1:0] SHIFT_RST = 8'h00;
   localparam logic [IR_LEN-1:0] ADDR_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

   // Backplane test pins as seen by the block
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
      logic tdo_line;
   } mai_pins_type;
   localparam int PINS_W = 5;

   // Standard TAP controller states
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0,
      TAP_IDLE = 4'h1,
      TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2,
      TAP_SHIFT_DR = 4'h6,
      TAP_EXIT1_DR = 4'h7,
      TAP_PAUSE_DR = 4'h5,
      TAP_EXIT2_DR = 4'h4,
      TAP_UPD_DR = 4'hC,
      TAP_SEL_IR = 4'hD,
      TAP_CAP_IR = 4'hF,
      TAP_SHIFT_IR = 4'hE,
      TAP_EXIT1_IR = 4'hA,
      TAP_PAUSE_IR = 4'hB,
      TAP_EXIT2_IR = 4'h9,
      TAP_UPD_IR = 4'h8
   } mai_tap_type;

   // Selection states of the bridge
   typedef enum logic [2:0] {
      SEL_WAIT_ADDR = 3'h0,
      SEL_INTERROG = 3'h1,
      SEL_WAIT_NEXT = 3'h3,
      SEL_WAIT_RESET = 3'h2,
      SEL_UNSEL = 3'h6,
      SEL_SINGLE = 3'h7,
      SEL_MULTI = 3'h5
   } mai_sel_type;

endpackage

// ### core/mai_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous levels; only the second stage reads the first.
`timescale 1ns/10ps
module mai_sync
   import mai_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // First stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// ### core/mai_tap.sv
// TAP controller for the backplane port, stepped on sampled test-clock rises.
// Assumes tck_rise is a one-cycle pulse and tms is already synchronised.
`timescale 1ns/10ps
module mai_tap
   import mai_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tck_rise,
   input wire logic tms,
   output mai_tap_type tap_ff
);
   mai_tap_type nxt_tap;

   // Standard 16-state transition table
   always_comb begin
      unique case (tap_ff)
         TAP_RESET: nxt_tap = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: nxt_tap = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: nxt_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nxt_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: nxt_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: nxt_tap = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: nxt_tap = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: nxt_tap = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: nxt_tap = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: nxt_tap = tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: nxt_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: nxt_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: nxt_tap = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: nxt_tap = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: nxt_tap = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: nxt_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // Moves only on a test-clock rise
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tap_ff <= TAP_RESET;
      end else if (tck_rise) begin
         tap_ff <= nxt_tap;
      end
   end
endmodule

// ### core/mai_top.sv
// Address interrogation logic of a multidrop backplane scan bridge.
// Assumes backplane pins arrive asynchronously; the test clock is sampled
// by clk_sys and its edges found here. The serial output line is resolved
// outside: a driven one is weak, a driven zero is strong.
`timescale 1ns/10ps
// Contract
// - From waiting for an address the selection moves to unselected, single, multi/broadcast or interrogation.
// - After reset or return-to-wait, Capture-IR loads a pattern whose two low bits are 01.
// - An interrogation opcode seen at Update-IR is copied into the address register.
// - The next Capture-IR in interrogation loads the inverse of the slot address pins.
// - During Shift-IR each driven bit is compared with the level seen on the output line.
// - A full address shifted without mismatch releases the output and goes to wait-for-reset at Update-IR.
// - A mismatch releases the output until the next shift, then the address is presented again.
// - A device that lost goes to wait-for-next-interrogation and joins the next instruction shift.
// - The output line is a wired-AND: a one is driven weakly and any zero wins.
// - Bits go least significant first on both the serial input and the output.
// - Any other opcode loaded during interrogation returns the device to waiting for an address.
// - The active-low backplane test reset returns everything to the power-up state.
module mai_top
   import mai_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input mai_pins_type bp_pins,
   input wire logic [SLOT_W-1:0] slot_addr,
   output logic tdo_b_o,
   output logic tdo_b_oe,
   output mai_sel_type sel_state,
   output logic [IR_LEN-1:0] ir_value,
   output logic [IR_LEN-1:0] addr_value
);
   mai_pins_type pins_s;
   logic [SLOT_W-1:0] slot_s;
   mai_tap_type tap;
   logic tck_d_ff;
   logic tck_rise;
   logic tck_fall;
   logic int_rst;
   logic upd_ir;
   logic in_interrog;
   logic mismatch;
   logic [IR_LEN-1:0] shift_ff;
   logic [IR_LEN-1:0] ir_ff;
   logic [IR_LEN-1:0] addr_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic contest_ff;
   logic won_ff;
   logic lost_ff;
   logic tdo_bit_ff;
   logic drive_ff;
   mai_sel_type sel_ff;
   mai_sel_type nxt_sel;

   // Pins and slot straps cross into clk_sys
   mai_sync #(.W(PINS_W)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(bp_pins),
      .sync_out(pins_s)
   );

   mai_sync #(.W(SLOT_W)) u_slot_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(slot_addr),
      .sync_out(slot_s)
   );

   // Test-clock edge finder on the synchronised level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tck_d_ff <= 1'b0;
      end else begin
         tck_d_ff <= pins_s.tck;
      end
   end

   assign tck_rise = pins_s.tck & ~tck_d_ff;
   assign tck_fall = ~pins_s.tck & tck_d_ff;
   // Pin reset or TAP reset both restore power-up state
   assign int_rst = rst | ~pins_s.trst_n | (tap == TAP_RESET);

   mai_tap u_tap (
      .clk_sys(clk_sys),
      .rst(rst | ~pins_s.trst_n),
      .tck_rise(tck_rise),
      .tms(pins_s.tms),
      .tap_ff(tap)
   );

   assign upd_ir = tck_fall & (tap == TAP_UPD_IR);
   assign in_interrog = (sel_ff == SEL_INTERROG) | (sel_ff == SEL_WAIT_NEXT);
   // Line sampled a half test-clock after the bit was launched
   assign mismatch = contest_ff & (pins_s.tdo_line != tdo_bit_ff);

   // Instruction shift register: capture, then LSB-first shift
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         shift_ff <= SHIFT_RST;
      end else if (tck_rise && tap == TAP_CAP_IR) begin
         if (in_interrog) begin
            shift_ff <= {PAD_BIT, ~slot_s};
         end else begin
            shift_ff <= CAPTURE_PAT;
         end
      end else if (tck_rise && tap == TAP_SHIFT_IR) begin
         shift_ff <= {pins_s.tdi, shift_ff[IR_LEN-1:1]};
      end
   end

   // Instruction and address registers taken at Update-IR
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         ir_ff <= ADDR_RST;
         addr_ff <= ADDR_RST;
      end else if (upd_ir) begin
         ir_ff <= shift_ff;
         if (shift_ff == INTERROG_OP) begin
            addr_ff <= shift_ff;
         end
      end
   end

   // Contest tracking over one instruction shift
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         contest_ff <= 1'b0;
         won_ff <= 1'b0;
         lost_ff <= 1'b0;
         cnt_ff <= CNT_RST;
      end else if (tck_rise && tap == TAP_CAP_IR) begin
         // Every contender, including earlier losers, rejoins here
         contest_ff <= in_interrog && ir_ff == INTERROG_OP;
         won_ff <= 1'b0;
         lost_ff <= 1'b0;
         cnt_ff <= CNT_RST;
      end else if (tck_rise && tap == TAP_SHIFT_IR && contest_ff) begin
         if (mismatch) begin
            contest_ff <= 1'b0;
            lost_ff <= 1'b1;
         end else if (cnt_ff == LAST_BIT) begin
            contest_ff <= 1'b0;
            won_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end

   // Output launched on the falling edge; released at once when out of contest
   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         tdo_bit_ff <= 1'b1;
         drive_ff <= 1'b0;
      end else if (tck_rise && tap == TAP_SHIFT_IR && contest_ff && (mismatch || cnt_ff == LAST_BIT)) begin
         drive_ff <= 1'b0;
      end else if (tck_fall) begin
         tdo_bit_ff <= shift_ff[0];
         drive_ff <= contest_ff && tap == TAP_SHIFT_IR;
      end
   end

   // Selection state machine, decided at Update-IR
   always_comb begin
      nxt_sel = sel_ff;
      if (upd_ir) begin
         if (shift_ff == RETURN_TO_WAIT_OP) begin
            nxt_sel = SEL_WAIT_ADDR;
         end else begin
            unique case (sel_ff)
               SEL_WAIT_ADDR: begin
                  if (shift_ff == INTERROG_OP) begin
                     nxt_sel = SEL_INTERROG;
                  end else if (shift_ff == {1'b0, slot_s}) begin
                     nxt_sel = SEL_SINGLE;
                  end else if (shift_ff == BROADCAST_OP || shift_ff[IR_LEN-1:2] == MULTICAST_BASE) begin
                     nxt_sel = SEL_MULTI;
                  end else begin
                     nxt_sel = SEL_UNSEL;
                  end
               end
               SEL_INTERROG, SEL_WAIT_NEXT: begin
                  if (shift_ff != INTERROG_OP) begin
                     nxt_sel = SEL_WAIT_ADDR;
                  end else if (won_ff) begin
                     nxt_sel = SEL_WAIT_RESET;
                  end else begin
                     nxt_sel = SEL_WAIT_NEXT;
                  end
               end
               SEL_WAIT_RESET: nxt_sel = SEL_WAIT_RESET;
               SEL_UNSEL, SEL_SINGLE, SEL_MULTI: nxt_sel = sel_ff;
               default: nxt_sel = SEL_WAIT_ADDR;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         sel_ff <= SEL_WAIT_ADDR;
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   assign tdo_b_o = tdo_bit_ff;
   assign tdo_b_oe = drive_ff;
   assign sel_state = sel_ff;
   assign ir_value = ir_ff;
   assign addr_value = addr_ff;

   // Checks, all in the clk_sys domain
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (int_rst);

   sequence upd_interrog_s;
      upd_ir && in_interrog && shift_ff == INTERROG_OP;
   endsequence

   sequence cap_ir_s;
      tck_rise && tap == TAP_CAP_IR;
   endsequence

   sequence shift_bit_s;
      tck_rise && tap == TAP_SHIFT_IR && contest_ff;
   endsequence

   wait_addr_exit_a: assert property (
      upd_ir && sel_ff == SEL_WAIT_ADDR && shift_ff != RETURN_TO_WAIT_OP |=>
      sel_ff inside {SEL_UNSEL, SEL_SINGLE, SEL_MULTI, SEL_INTERROG})
      else $error("bad exit from wait for address");

   capture_pattern_a: assert property (
      cap_ir_s and !in_interrog |=> shift_ff == CAPTURE_PAT)
      else $error("capture pattern not loaded");

   addr_load_a: assert property (
      upd_ir && sel_ff == SEL_WAIT_ADDR && shift_ff == INTERROG_OP |=>
      addr_ff == INTERROG_OP && sel_ff == SEL_INTERROG)
      else $error("interrogation opcode not taken");

   capture_inverse_a: assert property (
      cap_ir_s and in_interrog |=> shift_ff == {PAD_BIT, ~$past(slot_s)})
      else $error("inverted slot address not captured");

   compare_drop_a: assert property (
      shift_bit_s and mismatch |=> !contest_ff && lost_ff && !tdo_b_oe)
      else $error("mismatch not acted on");

   win_release_a: assert property (
      upd_interrog_s and won_ff |=> sel_ff == SEL_WAIT_RESET && !tdo_b_oe)
      else $error("winner did not release and wait");

   lost_quiet_a: assert property (
      lost_ff && tap != TAP_CAP_IR |-> !tdo_b_oe)
      else $error("loser still drives line");

   loser_next_a: assert property (
      upd_interrog_s and !won_ff |=> sel_ff == SEL_WAIT_NEXT)
      else $error("loser not waiting for next");

   lsb_first_a: assert property (
      tck_fall && tap == TAP_SHIFT_IR && contest_ff |=>
      tdo_b_o == $past(shift_ff[0]) && tdo_b_oe)
      else $error("bit order or drive wrong");

   other_op_exit_a: assert property (
      upd_ir && in_interrog && shift_ff != INTERROG_OP |=> sel_ff == SEL_WAIT_ADDR)
      else $error("interrogation not left");

   wait_reset_hold_a: assert property (
      sel_ff == SEL_WAIT_RESET && !(upd_ir && shift_ff == RETURN_TO_WAIT_OP) |=>
      sel_ff == SEL_WAIT_RESET && !tdo_b_oe)
      else $error("wait for reset left early");

   reset_state_a: assert property (@(posedge clk_sys) disable iff (rst)
      !pins_s.trst_n |=> sel_ff == SEL_WAIT_ADDR && !tdo_b_oe)
      else $error("test reset not honoured");
endmodule

// ### dv/mai_peer.sv
// Behavioural peer bridge that contests the shared backplane serial line.
// Assumes the bench raises shift_en only over the eight Shift-IR bits.
`timescale 1ns/10ps
module mai_peer (
   input wire logic tck,
   input wire logic shift_en,
   input wire logic [7:0] word,
   input wire logic line,
   output logic drv_o,
   output logic drv_oe
);
   logic contest = 1'b1;
   int cnt = 0;

   initial drv_o = 1'b1;
   initial drv_oe = 1'b0;

   // Drive on the fall, compare on the rise, drop out on a mismatch
   always @(tck) begin
      if (!shift_en) begin
         contest = 1'b1;
         cnt = 0;
         drv_oe = 1'b0;
      end else if (!tck) begin
         drv_oe = contest && (cnt < 8);
         drv_o = word[cnt[2:0]];
      end else if (drv_oe) begin
         if (line !== drv_o) begin
            contest = 1'b0;
            drv_oe = 1'b0;
         end else begin
            cnt++;
            // Released after the full word, line falls back to the pull-up
            if (cnt == 8) drv_oe = 1'b0;
         end
      end
   end
endmodule

// ### dv/multidrop_address_interrogation_tb.sv
// Self-checking bench for the interrogation block with one peer bridge.
// Assumes the bench acts as backplane master; the line is wired-AND with pull-up.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module multidrop_address_interrogation_tb;
   import mai_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic tck = 1'b0;
   logic tms = 1'b1;
   logic tdi = 1'b0;
   logic trst_n = 1'b1;
   logic peer_en = 1'b0;
   logic oe_hi = 1'b0;
   logic [SLOT_W-1:0] slot_addr = 7'h14;
   logic [7:0] peer_word = 8'hFE;
   logic [7:0] cap;
   logic tdo_b_o, tdo_b_oe, peer_o, peer_oe, b;
   logic [IR_LEN-1:0] ir_value, addr_value;
   mai_sel_type sel_state;
   mai_pins_type pins;
   wire line;
   int fails = 0;
   int checks = 0;
   localparam int NROW = 8;
   logic [7:0] row_op [NROW] = '{INTERROG_OP, {MULTICAST_BASE, 2'h0}, {MULTICAST_BASE, 2'h1},
      {MULTICAST_BASE, 2'h2}, BROADCAST_OP, 8'h14, 8'h55, RETURN_TO_WAIT_OP};
   mai_sel_type row_sel [NROW] = '{SEL_INTERROG, SEL_MULTI, SEL_MULTI, SEL_MULTI, SEL_MULTI,
      SEL_SINGLE, SEL_UNSEL, SEL_WAIT_ADDR};

   always #20 clk_sys = ~clk_sys;

   // Any enabled zero wins, otherwise the pull-up gives a weak one
   assign line = ~((tdo_b_oe & ~tdo_b_o) | (peer_oe & ~peer_o));
   assign pins = {tck, tms, tdi, trst_n, line};

   mai_top i_dut (.clk_sys(clk_sys), .rst(rst), .bp_pins(pins), .slot_addr(slot_addr),
      .tdo_b_o(tdo_b_o), .tdo_b_oe(tdo_b_oe), .sel_state(sel_state), .ir_value(ir_value),
      .addr_value(addr_value));

   mai_peer i_peer (.tck(tck), .shift_en(peer_en), .word(peer_word), .line(line),
      .drv_o(peer_o), .drv_oe(peer_oe));

   // One falling clock edge, noting any drive by the design
   task automatic step();
      @(negedge clk_sys);
      oe_hi = oe_hi | (tdo_b_oe === 1'b1);
   endtask

   // One test-clock period of eight system clocks; line read just before the rise
   task automatic tck_cycle(input logic m, input logic d, output logic seen);
      step();
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (3) step();
      step();
      seen = line;
      tck = 1'b1;
      repeat (3) step();
   endtask

   // Idle to Idle instruction scan, opcode sent LSB first
   task automatic ir_scan(input logic [7:0] op, input logic pe, output logic [7:0] got);
      tck_cycle(1'b1, 1'b0, b);
      tck_cycle(1'b1, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
      peer_en = pe;
      for (int i = 0; i < 8; i++) tck_cycle(i == 7, op[i], got[i]);
      peer_en = 1'b0;
      tck_cycle(1'b1, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
      repeat (8) step();
   endtask

   task automatic end_of_test();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      `CHK(sel_state, SEL_WAIT_ADDR)
      `CHK(tdo_b_oe, 1'b0)
      repeat (4) step();
      tck_cycle(1'b0, 1'b0, b);
      // Every selection reached from waiting for an address
      for (int r = 0; r < NROW; r++) begin
         ir_scan(RETURN_TO_WAIT_OP, 1'b0, cap);
         ir_scan(row_op[r], 1'b0, cap);
         `CHK(sel_state, row_sel[r])
         `CHK(ir_value, row_op[r])
         if (row_op[r] == INTERROG_OP) `CHK(addr_value, INTERROG_OP)
      end
      // Peer with the lower inverted bit wins, design waits and retries
      ir_scan(RETURN_TO_WAIT_OP, 1'b0, cap);
      ir_scan(INTERROG_OP, 1'b0, cap);
      ir_scan(INTERROG_OP, 1'b1, cap);
      `CHK(cap, 8'hFE)
      `CHK(sel_state, SEL_WAIT_NEXT)
      ir_scan(INTERROG_OP, 1'b0, cap);
      `CHK(cap, {PAD_BIT, ~slot_addr})
      `CHK(sel_state, SEL_WAIT_RESET)
      oe_hi = 1'b0;
      ir_scan(INTERROG_OP, 1'b0, cap);
      `CHK(cap, 8'hFF)
      `CHK(oe_hi, 1'b0)
      `CHK(sel_state, SEL_WAIT_RESET)
      ir_scan(RETURN_TO_WAIT_OP, 1'b0, cap);
      `CHK(sel_state, SEL_WAIT_ADDR)
      // Design wins on bit 0 against a peer presenting a one there
      slot_addr = 7'h01;
      peer_word = 8'hEB;
      ir_scan(INTERROG_OP, 1'b0, cap);
      ir_scan(INTERROG_OP, 1'b1, cap);
      `CHK(cap, 8'hFE)
      `CHK(sel_state, SEL_WAIT_RESET)
      // Loss on bit 1, then a foreign opcode ends interrogation
      ir_scan(RETURN_TO_WAIT_OP, 1'b0, cap);
      peer_word = 8'hFC;
      ir_scan(INTERROG_OP, 1'b0, cap);
      ir_scan(INTERROG_OP, 1'b1, cap);
      `CHK(cap, 8'hFC)
      `CHK(sel_state, SEL_WAIT_NEXT)
      ir_scan(8'h55, 1'b0, cap);
      `CHK(sel_state, SEL_WAIT_ADDR)
      // Test reset in mid interrogation
      ir_scan(INTERROG_OP, 1'b0, cap);
      trst_n = 1'b0;
      repeat (8) step();
      `CHK(sel_state, SEL_WAIT_ADDR)
      `CHK(ir_value, 8'h00)
      `CHK(addr_value, 8'h00)
      `CHK(tdo_b_oe, 1'b0)
      trst_n = 1'b1;
      repeat (4) step();
      end_of_test();
   end
endmodule
